//--- sds_pkg.sv
// Constants, field layouts and decode helpers for the dual-select sensor access block.
// Assumes a single core clock domain; the bus pins are synchronised inside the block.
package sds_pkg;

    // Converter command decode.
    localparam logic [3:0] SDS_CMD_WRITE_NIBBLE = 4'h4;
    localparam logic [7:0] SDS_CMD_RESET = 8'h06;

    // Memory fetch instruction layout: upper nibble zero, low three bits fixed.
    localparam logic [3:0] SDS_MEM_INSTR_HIGH = 4'h0;
    localparam logic [2:0] SDS_MEM_INSTR_LOW = 3'h3;
    localparam int SDS_MEM_ADDR_HIGH_POS = 3;
    localparam int SDS_MEM_DEPTH = 512;
    localparam logic [4:0] SDS_MEM_HDR_BITS = 5'h10;

    // Converter frame geometry.
    localparam int SDS_CONV_BITS = 24;
    localparam logic [4:0] SDS_FRAME_LAST_BIT = 5'h1F;

    // Configuration register indices and values after reset.
    localparam logic [1:0] SDS_CFG_RATE_SRC_IDX = 2'h1;
    localparam logic [7:0] SDS_CFG0_RST = 8'h00;
    localparam logic [7:0] SDS_CFG1_RST = 8'h04;
    localparam logic [7:0] SDS_CFG2_RST = 8'h00;
    localparam logic [7:0] SDS_CFG3_RST = 8'h00;

    // Field positions inside the rate and source register.
    localparam int SDS_RATE_MSB = 7;
    localparam int SDS_RATE_LSB = 5;
    localparam int SDS_MODE_MSB = 4;
    localparam int SDS_MODE_LSB = 3;
    localparam int SDS_SRC_POS = 1;

    // Operating modes and their modulator clocks in kHz.
    localparam logic [1:0] SDS_MODE_NORMAL = 2'h0;
    localparam logic [1:0] SDS_MODE_FAST = 2'h2;
    localparam logic [9:0] SDS_MOD_KHZ_NORMAL = 10'h100;
    localparam logic [9:0] SDS_MOD_KHZ_FAST = 10'h200;

    // Command parser states.
    typedef enum logic [0:0] {SDS_ST_CMD, SDS_ST_DATA} sds_cmd_state_t;

    // Samples per second for a rate code and mode; zero marks an unused code.
    function automatic logic [10:0] sds_rate_sps(input logic [2:0] rate, input logic [1:0] mode);
        logic [10:0] sps;
        sps = 11'h000;
        if (mode == SDS_MODE_NORMAL) begin
            case (rate)
                3'h0: sps = 11'h014;
                3'h1: sps = 11'h02D;
                3'h2: sps = 11'h05A;
                3'h3: sps = 11'h0AF;
                3'h4: sps = 11'h14A;
                3'h5: sps = 11'h258;
                3'h6: sps = 11'h3E8;
                default: sps = 11'h000;
            endcase
        end else if (mode == SDS_MODE_FAST) begin
            case (rate)
                3'h0: sps = 11'h028;
                3'h1: sps = 11'h05A;
                3'h2: sps = 11'h0B4;
                3'h3: sps = 11'h15E;
                3'h4: sps = 11'h294;
                3'h5: sps = 11'h4B0;
                3'h6: sps = 11'h7D0;
                default: sps = 11'h000;
            endcase
        end
        return sps;
    endfunction

endpackage

//--- sds_access.sv
// Serial access logic of a sensor with a calibration memory and a converter on one shared bus.
// Assumes the host drives the bus clock and both selects; the bus pins are asynchronous to core_clk.
//
// Summary of operation
// - Memory ignores the bus while its select is high, active while low.
// - Memory transfers use clock polarity/phase (0,0) or (1,1).
// - After the last address bit the memory shifts the byte out MSB first.
// - Continued clocking advances the memory pointer and outputs the next location.
// - Memory pointer wraps from highest to lowest address, read never ends.
// - Converter idles while its select is high, active while low.
// - Converter transfers use clock polarity 0 and phase 1.
// - Write command is 0100, start register in bits 3:2, count minus one in 1:0.
// - Start 0 count field 3 loads registers 0 to 3 in sequence.
// - Commands are decoded full-duplex on any byte boundary of a data read.
// - A write during a data read does not corrupt the data shifted out.
// - New settings apply and conversion restarts once the command is fully clocked in.
// - Register 1 holds rate code 7:5, mode 4:3, source flag bit 1.
// - Normal mode rate codes select 20 to 1000 samples per second.
// - Mode 00 normal at 256 kHz, mode 10 fast at 512 kHz with doubled rates.
// - Source flag 0 converts pressure, 1 converts temperature.
// - The reset command returns every setting to its default.
// - Data output starts at the first rising clock edge after the converter select goes low.
`timescale 1ns/1ns
`default_nettype none
module sds_access
    import sds_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic memory_select_n,
    input wire logic converter_select_n,
    input wire logic serial_din,
    output logic serial_dout,
    output logic serial_dout_oe,
    input wire logic [SDS_CONV_BITS-1:0] conv_data,
    input wire logic cal_load_en,
    input wire logic [8:0] cal_load_addr,
    input wire logic [7:0] cal_load_data,
    output logic [7:0] config_byte0,
    output logic [7:0] config_byte1,
    output logic [7:0] config_byte2,
    output logic [7:0] config_byte3,
    output logic [2:0] rate_code,
    output logic [1:0] operating_mode,
    output logic reading_source_flag,
    output logic [10:0] sample_rate_sps,
    output logic [9:0] modulator_khz,
    output logic settings_applied
);
    import sds_pkg::*;

    // Synchroniser stages for sclk, memory select, converter select and data in (bits 3..0).
    logic [3:0] pin_s0_q, pin_s1_q, pin_s2_q, pin_f_q, pin_prev_q;
    logic sclk_rise, sclk_fall, mem_sel, cnv_sel, din;

    // Calibration memory and its read state.
    logic [7:0] cal_mem [0:SDS_MEM_DEPTH-1];
    logic [4:0] mem_cnt_q;
    logic [15:0] mem_hdr_q;
    logic mem_data_q;
    logic [2:0] mem_bit_q;
    logic [8:0] mem_addr_q;
    logic [15:0] mem_hdr_full;
    logic [7:0] mem_byte;

    // Converter state.
    logic [7:0] cfg_q [0:3];
    logic [7:0] pend_q [0:3];
    logic [2:0] rx_cnt_q;
    logic [6:0] rx_sh_q;
    logic [4:0] out_cnt_q;
    logic [SDS_CONV_BITS-1:0] out_sh_q;
    sds_cmd_state_t cmd_st_q;
    logic [1:0] wr_idx_q;
    logic [1:0] wr_left_q;
    logic [7:0] rx_byte;
    logic rx_done;

    // Three flops per pin; the filtered level moves once stages two and three agree.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s0_q <= 4'hF;
            pin_s1_q <= 4'hF;
            pin_s2_q <= 4'hF;
            pin_f_q <= 4'hF;
            pin_prev_q <= 4'hF;
        end else begin
            pin_s0_q <= {sclk, memory_select_n, converter_select_n, serial_din};
            pin_s1_q <= pin_s0_q;
            pin_s2_q <= pin_s1_q;
            pin_f_q <= (pin_s2_q & ~(pin_s1_q ^ pin_s2_q)) | (pin_f_q & (pin_s1_q ^ pin_s2_q));
            pin_prev_q <= pin_f_q;
        end
    end

    // Edge and level view of the filtered pins.
    assign sclk_rise = pin_f_q[3] & ~pin_prev_q[3];
    assign sclk_fall = ~pin_f_q[3] & pin_prev_q[3];
    assign mem_sel = ~pin_f_q[2];
    assign cnv_sel = ~pin_f_q[1];
    assign din = pin_f_q[0];

    // Calibration memory contents come from the user-side load port.
    always_ff @(posedge core_clk) begin
        if (cal_load_en) begin
            cal_mem[cal_load_addr] <= cal_load_data;
        end
    end

    assign mem_hdr_full = {mem_hdr_q[14:0], din};
    assign mem_byte = cal_mem[mem_addr_q];

    // Memory header capture on rising edges; both allowed modes sample on the rising edge.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_cnt_q <= 5'h00;
            mem_hdr_q <= 16'h0000;
            mem_data_q <= 1'b0;
        end else if (!mem_sel) begin
            mem_cnt_q <= 5'h00;
            mem_data_q <= 1'b0;
        end else if (sclk_rise && mem_cnt_q != SDS_MEM_HDR_BITS) begin
            mem_hdr_q <= mem_hdr_full;
            mem_cnt_q <= mem_cnt_q + 5'h01;
            if (mem_cnt_q == SDS_MEM_HDR_BITS - 5'h01) begin
                mem_data_q <= (mem_hdr_full[15:12] == SDS_MEM_INSTR_HIGH)
                    && (mem_hdr_full[10:8] == SDS_MEM_INSTR_LOW);
            end
        end
    end

    // Memory pointer: loaded from the header, advanced after each byte and wrapping at the top.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr_q <= 9'h000;
            mem_bit_q <= 3'h0;
        end else if (mem_sel && sclk_rise && mem_cnt_q == SDS_MEM_HDR_BITS - 5'h01) begin
            mem_addr_q <= {mem_hdr_full[8 + SDS_MEM_ADDR_HIGH_POS], mem_hdr_full[7:0]};
            mem_bit_q <= 3'h0;
        end else if (mem_sel && mem_data_q && sclk_fall) begin
            mem_bit_q <= mem_bit_q + 3'h1;
            if (mem_bit_q == 3'h7) begin
                mem_addr_q <= mem_addr_q + 9'h001;
            end
        end
    end

    // Converter byte alignment; input is sampled on falling edges in clock phase 1.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_cnt_q <= 3'h0;
            rx_sh_q <= 7'h00;
        end else if (!cnv_sel) begin
            rx_cnt_q <= 3'h0;
        end else if (sclk_fall) begin
            rx_sh_q <= {rx_sh_q[5:0], din};
            rx_cnt_q <= rx_cnt_q + 3'h1;
        end
    end

    assign rx_byte = {rx_sh_q, din};
    assign rx_done = cnv_sel && sclk_fall && rx_cnt_q == 3'h7;

    // Command parser: runs beside the data read and acts on every completed byte.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_st_q <= SDS_ST_CMD;
            wr_idx_q <= 2'h0;
            wr_left_q <= 2'h0;
            settings_applied <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                pend_q[i] <= 8'h00;
            end
            cfg_q[0] <= SDS_CFG0_RST;
            cfg_q[1] <= SDS_CFG1_RST;
            cfg_q[2] <= SDS_CFG2_RST;
            cfg_q[3] <= SDS_CFG3_RST;
        end else begin
            settings_applied <= 1'b0;
            if (!cnv_sel) begin
                cmd_st_q <= SDS_ST_CMD;
            end else if (rx_done) begin
                case (cmd_st_q)
                    SDS_ST_CMD: begin
                        if (rx_byte[7:4] == SDS_CMD_WRITE_NIBBLE) begin
                            cmd_st_q <= SDS_ST_DATA;
                            wr_idx_q <= rx_byte[3:2];
                            wr_left_q <= rx_byte[1:0];
                            for (int i = 0; i < 4; i++) begin
                                pend_q[i] <= cfg_q[i];
                            end
                        end else if (rx_byte == SDS_CMD_RESET) begin
                            cfg_q[0] <= SDS_CFG0_RST;
                            cfg_q[1] <= SDS_CFG1_RST;
                            cfg_q[2] <= SDS_CFG2_RST;
                            cfg_q[3] <= SDS_CFG3_RST;
                            settings_applied <= 1'b1;
                        end
                    end
                    SDS_ST_DATA: begin
                        wr_idx_q <= wr_idx_q + 2'h1;
                        wr_left_q <= wr_left_q - 2'h1;
                        if (wr_left_q == 2'h0) begin
                            // All bytes in: commit staged values at once and restart conversion.
                            for (int i = 0; i < 4; i++) begin
                                cfg_q[i] <= (wr_idx_q == 2'(i)) ? rx_byte : pend_q[i];
                            end
                            settings_applied <= 1'b1;
                            cmd_st_q <= SDS_ST_CMD;
                        end else begin
                            pend_q[wr_idx_q] <= rx_byte;
                        end
                    end
                    default: cmd_st_q <= SDS_ST_CMD;
                endcase
            end
        end
    end

    // Conversion data shift; a command never touches it, so the read stays intact.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_cnt_q <= 5'h00;
            out_sh_q <= '0;
        end else if (!cnv_sel) begin
            out_cnt_q <= 5'h00;
        end else if (sclk_rise) begin
            if (out_cnt_q != SDS_FRAME_LAST_BIT) begin
                out_cnt_q <= out_cnt_q + 5'h01;
            end
            if (out_cnt_q == 5'h00) begin
                out_sh_q <= {conv_data[SDS_CONV_BITS-2:0], 1'b0};
            end else begin
                out_sh_q <= {out_sh_q[SDS_CONV_BITS-2:0], 1'b0};
            end
        end
    end

    // Shared data pin: memory updates on falling edges, converter on rising edges.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_dout <= 1'b0;
            serial_dout_oe <= 1'b0;
        end else begin
            serial_dout_oe <= (mem_sel && mem_data_q) || cnv_sel;
            if (mem_sel && mem_data_q && sclk_fall) begin
                serial_dout <= mem_byte[3'h7 - mem_bit_q];
            end else if (cnv_sel && sclk_rise) begin
                serial_dout <= (out_cnt_q == 5'h00) ? conv_data[SDS_CONV_BITS-1] : out_sh_q[SDS_CONV_BITS-1];
            end
        end
    end

    // Decoded settings presented from flops.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_code <= 3'h0;
            operating_mode <= SDS_MODE_NORMAL;
            reading_source_flag <= 1'b0;
            sample_rate_sps <= 11'h000;
            modulator_khz <= 10'h000;
        end else begin
            rate_code <= cfg_q[SDS_CFG_RATE_SRC_IDX][SDS_RATE_MSB:SDS_RATE_LSB];
            operating_mode <= cfg_q[SDS_CFG_RATE_SRC_IDX][SDS_MODE_MSB:SDS_MODE_LSB];
            reading_source_flag <= cfg_q[SDS_CFG_RATE_SRC_IDX][SDS_SRC_POS];
            sample_rate_sps <= sds_rate_sps(rate_code, operating_mode);
            if (operating_mode == SDS_MODE_NORMAL) begin
                modulator_khz <= SDS_MOD_KHZ_NORMAL;
            end else if (operating_mode == SDS_MODE_FAST) begin
                modulator_khz <= SDS_MOD_KHZ_FAST;
            end else begin
                modulator_khz <= 10'h000;
            end
        end
    end

    // Raw register contents for the analogue front end.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_byte0 <= SDS_CFG0_RST;
            config_byte1 <= SDS_CFG1_RST;
            config_byte2 <= SDS_CFG2_RST;
            config_byte3 <= SDS_CFG3_RST;
        end else begin
            config_byte0 <= cfg_q[0];
            config_byte1 <= cfg_q[1];
            config_byte2 <= cfg_q[2];
            config_byte3 <= cfg_q[3];
        end
    end

    // Checks kept beside the logic they guard.
    AST_MEM_STANDBY: assert property (@(posedge core_clk) disable iff (!arst_n)
        !mem_sel && !cnv_sel |=> !serial_dout_oe)
        else $error("Data pin driven while both targets are deselected.");

    AST_CNV_ACTIVE: assert property (@(posedge core_clk) disable iff (!arst_n)
        cnv_sel |=> serial_dout_oe)
        else $error("Converter selected but data pin not driven.");

    AST_MEM_ADVANCE: assert property (@(posedge core_clk) disable iff (!arst_n)
        mem_sel && mem_data_q && sclk_fall && mem_bit_q == 3'h7 && mem_addr_q != 9'h1FF
        |=> mem_addr_q == $past(mem_addr_q) + 9'h001)
        else $error("Memory pointer did not advance after a byte.");

    AST_MEM_WRAP: assert property (@(posedge core_clk) disable iff (!arst_n)
        mem_sel && mem_data_q && sclk_fall && mem_bit_q == 3'h7 && mem_addr_q == 9'h1FF
        |=> mem_addr_q == 9'h000 && mem_data_q)
        else $error("Memory pointer did not wrap to zero.");

    AST_MEM_FIRST_BIT: assert property (@(posedge core_clk) disable iff (!arst_n)
        mem_sel && mem_data_q && sclk_fall && mem_bit_q == 3'h0 |=> serial_dout == $past(mem_byte[7]))
        else $error("Memory byte did not start with its MSB.");

    AST_RESET_CMD: assert property (@(posedge core_clk) disable iff (!arst_n)
        rx_done && cmd_st_q == SDS_ST_CMD && rx_byte == SDS_CMD_RESET
        |=> ##2 rate_code == 3'h0 && operating_mode == SDS_MODE_NORMAL && !reading_source_flag)
        else $error("Reset command did not restore defaults.");

    AST_RATE_NORMAL: assert property (@(posedge core_clk) disable iff (!arst_n)
        operating_mode == SDS_MODE_NORMAL && rate_code == 3'h3 && $stable(rate_code) && $stable(operating_mode)
        |=> sample_rate_sps == 11'h0AF)
        else $error("Normal mode rate code 3 is not 175 samples per second.");

    AST_RATE_FAST: assert property (@(posedge core_clk) disable iff (!arst_n)
        operating_mode == SDS_MODE_FAST && rate_code == 3'h3 && $stable(rate_code) && $stable(operating_mode)
        |=> sample_rate_sps == 11'h15E && modulator_khz == SDS_MOD_KHZ_FAST)
        else $error("Fast mode rate code 3 is not 350 samples per second.");

    AST_READ_INTACT: assert property (@(posedge core_clk) disable iff (!arst_n)
        cnv_sel && sclk_rise && out_cnt_q != 5'h00 |=> out_sh_q == {$past(out_sh_q[SDS_CONV_BITS-2:0]), 1'b0})
        else $error("Conversion data disturbed during a read.");

    AST_CMD_KEEPS_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
        rx_done |=> $stable(out_sh_q) && $stable(out_cnt_q))
        else $error("Command decode touched the conversion read.");

endmodule
`default_nettype wire

//--- sds_host_model.sv
// Host model: bus master that drives the bus clock, both selects and the data line toward the sensor.
// Assumes it is paced by the falling edge of the core clock and that the bench calls its tasks.
`timescale 1ns/1ns
`default_nettype none
module sds_host_model (
    input wire logic core_clk,
    output logic sclk,
    output logic memory_select_n,
    output logic converter_select_n,
    output logic serial_din,
    input wire logic serial_dout,
    input wire logic serial_dout_oe
);
    logic oe_all;

    // The bus starts idle with both targets deselected, so only one can ever drive the data line.
    initial begin
        sclk = 1'b0;
        memory_select_n = 1'b1;
        converter_select_n = 1'b1;
        serial_din = 1'b0;
        oe_all = 1'b1;
    end

    // Waits half a bus clock period, counted in core cycles.
    task automatic half();
        repeat (8) @(negedge core_clk);
    endtask

    // Moves one bit; mode 0 is (0,0), mode 1 is (1,1), mode 2 is (0,1) with data driven on the rise.
    task automatic xfer_bit(input int mode, input logic b, output logic r);
        if (mode == 2) begin
            sclk = 1'b1;
        end else if (mode == 1) begin
            sclk = 1'b0;
        end
        serial_din = b;
        half();
        r = serial_dout_oe ? serial_dout : ~serial_dout; // A released line reads as the inverse.
        oe_all = oe_all & serial_dout_oe;
        sclk = (mode != 2);
        half();
        if (mode == 0) begin
            sclk = 1'b0;
        end
    endtask

    // Ends a transfer by raising the selects; the data line then shows the inverse of its last bit.
    task automatic end_frame();
        memory_select_n = 1'b1;
        converter_select_n = 1'b1;
        serial_din = ~serial_din;
        half();
        sclk = 1'b0;
        half();
    endtask

    // Sends a 16-bit fetch header and reads n bytes back, last byte in bits 7:0 (first byte in the top bits when n is 4).
    task automatic mem_read(input int mode, input logic [15:0] hdr, input int n, output logic [31:0] rd);
        logic r;
        rd = '0;
        sclk = (mode == 1);
        half();
        memory_select_n = 1'b0;
        half();
        for (int i = 15; i >= 0; i--) xfer_bit(mode, hdr[i], r);
        oe_all = 1'b1;
        for (int i = 0; i < 8 * n; i++) begin
            xfer_bit(mode, 1'b0, r);
            rd = {rd[30:0], r};
        end
        end_frame();
    endtask

    // Runs a converter frame of n bytes; commands ride on the byte boundaries of the read.
    task automatic conv_frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        logic r;
        rx = '0;
        oe_all = 1'b1;
        converter_select_n = 1'b0;
        half();
        for (int i = 0; i < 8 * n; i++) begin
            xfer_bit(2, tx[8 * n - 1 - i], r);
            rx = {rx[62:0], r};
        end
        end_frame();
    endtask
endmodule
`default_nettype wire

//--- sds_access_tb.sv
// Self-checking bench for the dual-select sensor access block with a host model on the bus.
// Assumes the design package is compiled first; expectations come from the functions below.
`timescale 1ns/1ns
`default_nettype none
module sds_access_tb;
    import sds_pkg::*;
    logic core_clk, arst_n, sclk, memory_select_n, converter_select_n, serial_din, serial_dout, serial_dout_oe;
    logic [SDS_CONV_BITS-1:0] conv_data;
    logic cal_load_en;
    logic [8:0] cal_load_addr, a9;
    logic [7:0] cal_load_data, config_byte0, config_byte1, config_byte2, config_byte3, v;
    logic [2:0] rate_code;
    logic [1:0] operating_mode;
    logic reading_source_flag, settings_applied;
    logic [10:0] sample_rate_sps;
    logic [9:0] modulator_khz;
    logic [31:0] rd;
    logic [63:0] tx, rx;
    logic [7:0] mem [SDS_MEM_DEPTH];
    logic [7:0] cfg [4];
    int miscompares = 0, checked = 0, applied_cnt = 0, exp_applied = 0, k;

    // Core clock and a count of settings-applied pulses.
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (settings_applied === 1'b1) applied_cnt++;

    sds_access sds_access_inst (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk),
        .memory_select_n(memory_select_n), .converter_select_n(converter_select_n), .serial_din(serial_din),
        .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe), .conv_data(conv_data),
        .cal_load_en(cal_load_en), .cal_load_addr(cal_load_addr), .cal_load_data(cal_load_data),
        .config_byte0(config_byte0), .config_byte1(config_byte1), .config_byte2(config_byte2),
        .config_byte3(config_byte3), .rate_code(rate_code), .operating_mode(operating_mode),
        .reading_source_flag(reading_source_flag), .sample_rate_sps(sample_rate_sps),
        .modulator_khz(modulator_khz), .settings_applied(settings_applied));

    sds_host_model sds_host_model_inst (.core_clk(core_clk), .sclk(sclk), .memory_select_n(memory_select_n),
        .converter_select_n(converter_select_n), .serial_din(serial_din), .serial_dout(serial_dout),
        .serial_dout_oe(serial_dout_oe));

    // Expected samples per second for a rate code and mode; zero for unused codes.
    function automatic logic [31:0] exp_sps(input logic [2:0] r, input logic [1:0] m);
        int nrm[7] = '{20, 45, 90, 175, 330, 600, 1000};
        int fst[7] = '{40, 90, 180, 350, 660, 1200, 2000};
        if (r == 3'h7) return 32'h0;
        if (m == 2'h0) return 32'(nrm[r]);
        if (m == 2'h2) return 32'(fst[r]);
        return 32'h0;
    endfunction

    // Expected modulator clock in kHz for a mode.
    function automatic logic [31:0] exp_khz(input logic [1:0] m);
        return (m == 2'h0) ? 32'h100 : (m == 2'h2) ? 32'h200 : 32'h0;
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Waits, with a bound, until the pulse count reaches n, then lets the decode chain settle.
    task automatic wait_applied(input int n);
        k = 0;
        while (applied_cnt != n && k < 200) begin
            @(negedge core_clk);
            k++;
        end
        if (applied_cnt != n) begin
            miscompares++;
            test_done();
        end
        repeat (4) @(negedge core_clk);
    endtask

    // Checks all registers and decoded settings against the bench's copy.
    task automatic chk_cfg();
        chk_val(32'(config_byte0), 32'(cfg[0]));
        chk_val(32'(config_byte1), 32'(cfg[1]));
        chk_val(32'(config_byte2), 32'(cfg[2]));
        chk_val(32'(config_byte3), 32'(cfg[3]));
        chk_val(32'(rate_code), 32'(cfg[1][7:5]));
        chk_val(32'(operating_mode), 32'(cfg[1][4:3]));
        chk_val(32'(reading_source_flag), 32'(cfg[1][1]));
        chk_val(32'(sample_rate_sps), exp_sps(cfg[1][7:5], cfg[1][4:3]));
        chk_val(32'(modulator_khz), exp_khz(cfg[1][4:3]));
    endtask

    // Sends one converter frame, counts the expected commit and checks the settings.
    task automatic cmd(input logic [63:0] t, input int n, input bit commit);
        sds_host_model_inst.conv_frame(t, n, rx);
        if (commit) exp_applied++;
        wait_applied(exp_applied);
        chk_val(32'(sds_host_model_inst.oe_all), 32'h1);
        chk_cfg();
    endtask

    // Watchdog against a hang anywhere in the run.
    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        test_done();
    end

    // Main sequence.
    initial begin
        arst_n = 1'b0;
        conv_data = '0;
        cal_load_en = 1'b0;
        cal_load_addr = 9'h000;
        cal_load_data = 8'h00;
        void'($urandom(93));
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        cfg = '{SDS_CFG0_RST, SDS_CFG1_RST, SDS_CFG2_RST, SDS_CFG3_RST};
        chk_cfg();
        $display("Reset defaults test done");
        cal_load_en = 1'b1;
        for (int a = 0; a < SDS_MEM_DEPTH; a++) begin
            mem[a] = 8'($urandom);
            cal_load_addr = 9'(a);
            cal_load_data = mem[a];
            @(negedge core_clk);
        end
        cal_load_en = 1'b0;
        for (int t = 0; t < 4; t++) begin
            a9 = (t == 0) ? 9'h1FE : (t == 1) ? 9'h0FF : 9'($urandom);
            sds_host_model_inst.mem_read(t % 2, {4'h0, a9[8], 3'h3, a9[7:0]}, 4, rd);
            for (int b = 0; b < 4; b++) chk_val(32'(rd[31-8*b -: 8]), 32'(mem[9'(a9 + b)]));
            chk_val(32'(sds_host_model_inst.oe_all), 32'h1);
            chk_val(32'(serial_dout_oe), 32'h0);
        end
        sds_host_model_inst.mem_read(0, 16'h1303, 1, rd);
        chk_val(32'(sds_host_model_inst.oe_all), 32'h0);
        $display("Memory read test done");
        // Power-up sequence: reset command, then all four registers from calibration memory, register 1 with bit 2 set and bit 0 cleared.
        cmd(64'h06, 1, 1'b1);
        cfg = '{mem[61], {mem[63][7:3], 1'b1, mem[63][1], 1'b0}, mem[65], mem[67]};
        conv_data = 24'($urandom);
        cmd({24'h0, 8'h43, cfg[0], cfg[1], cfg[2], cfg[3]}, 5, 1'b1);
        chk_val(32'(rx[39:16]), 32'(conv_data));
        chk_val(32'(rx[15:0]), 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = {(i < 4) ? 3'h3 : 3'(i + 3), 2'(i), 1'b1, 1'($urandom), 1'b0};
            conv_data = 24'($urandom);
            tx = 64'h0;
            tx[31-8*(i%3) -: 8] = 8'h44;
            tx[23-8*(i%3) -: 8] = v;
            cfg[1] = v;
            cmd(tx, 4, 1'b1);
            chk_val(32'(rx[31:8]), 32'(conv_data));
            chk_val(32'(rx[7:0]), 32'h0);
        end
        $display("Full-duplex write test done");
        cfg = '{SDS_CFG0_RST, SDS_CFG1_RST, SDS_CFG2_RST, SDS_CFG3_RST};
        cmd(64'h06, 1, 1'b1);
        cfg[3] = mem[67];
        cmd({48'h0, 8'h4C, mem[67]}, 2, 1'b1);
        cmd({48'h0, 8'h41, 8'hA5}, 2, 1'b0);
        $display("Reset and single write test done");
        test_done();
    end
endmodule
`default_nettype wire
